// ===== core/trng_digitizer.sv
/*
 * coherent-sampling trng digitizer: decimator, 256-bit output buffer, jitter
 * measurement by reordered accumulation, pll lock gating and a register port.
 * assumes the jittery phases come from plls whose factors are fixed at build time.
 */
module trng_digitizer import trng_digitizer_pkg::*; #(
	parameter int KM = KM_DEF,
	parameter int KD = KD_DEF,
	parameter int NPH = NPH_DEF,
	parameter int ACC_N = ACC_N_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [NPH-1:0] phase_i,
	input wire logic [LOCK_NUM-1:0] lock_i,
	input wire reg_req_s reg_req_i,
	output logic [DATA_W-1:0] rd_data_o,
	output raw_bit_s raw_o,
	output logic test_sample_o,
	output logic alarm_o
);

	localparam int POS_W = $clog2(KD);
	localparam int ACC_W = $clog2(ACC_N + 1);
	localparam int RND_W = $clog2(ACC_N);
	localparam int UC_W = $clog2(KD + 1);
	localparam int BC_W = $clog2(OBUF_BITS + 1);
	localparam logic [POS_W-1:0] KD_LAST = POS_W'(KD - 1);
	localparam logic [POS_W:0] KD_EXT = (POS_W + 1)'(KD);
	localparam logic [POS_W:0] KM_STEP = (POS_W + 1)'(KM % KD);
	localparam logic [RND_W-1:0] RND_LAST = RND_W'(ACC_N - 1);
	localparam logic [ACC_W-1:0] ACC_FULL = ACC_W'(ACC_N);
	localparam logic [BC_W-1:0] BUF_CNT_FULL = BC_W'(OBUF_BITS);

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	logic sample;
	logic clr_ff;
	logic nxt_clr;
	logic run_ff;
	logic nxt_run;

	phase_sampler #(
		.NPH(NPH)
	) u_sampler (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.clr_i(clr_ff),
		.phase_i(phase_i),
		.sample_o(sample)
	);

	// decimator and period counter
	logic [POS_W-1:0] cnt_ff;
	logic [POS_W-1:0] nxt_cnt;
	logic dec_ff;
	logic nxt_dec;
	logic end_period;
	logic period_bit;
	logic locked_all;

	assign end_period = cnt_ff == KD_LAST;
	assign period_bit = dec_ff ^ sample;
	assign locked_all = &lock_i;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_dec = dec_ff;
		if (clr_ff) begin
			nxt_cnt = '0;
			nxt_dec = 1'h0;
		end else if (end_period) begin
			nxt_cnt = '0;
			nxt_dec = 1'h0;
		end else begin
			nxt_cnt = cnt_ff + POS_W'(1);
			nxt_dec = period_bit;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
			dec_ff <= 1'h0;
		end else begin
			cnt_ff <= nxt_cnt;
			dec_ff <= nxt_dec;
		end
	end

	// raw bit stream to the post-processing generator
	raw_bit_s raw_ff;
	raw_bit_s nxt_raw;
	logic tsamp_ff;
	logic nxt_tsamp;

	always_comb begin
		nxt_raw.data = raw_ff.data;
		nxt_raw.valid = 1'h0;
		if (!clr_ff && end_period) begin
			nxt_raw.data = period_bit;
			nxt_raw.valid = run_ff && locked_all;
		end
		nxt_tsamp = sample;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			raw_ff <= '0;
			tsamp_ff <= 1'h0;
		end else begin
			raw_ff <= nxt_raw;
			tsamp_ff <= nxt_tsamp;
		end
	end

	// 256-bit output buffer; newest bit enters at bit 0
	logic [OBUF_BITS-1:0] obuf_ff;
	logic [OBUF_BITS-1:0] nxt_obuf;
	logic [BC_W-1:0] bcnt_ff;
	logic [BC_W-1:0] nxt_bcnt;

	always_comb begin
		nxt_obuf = obuf_ff;
		nxt_bcnt = bcnt_ff;
		if (clr_ff) begin
			nxt_bcnt = '0;
		end else if (end_period && locked_all) begin
			nxt_obuf = {obuf_ff[OBUF_BITS-2:0], period_bit};
			if (bcnt_ff != BUF_CNT_FULL) begin
				nxt_bcnt = bcnt_ff + BC_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			obuf_ff <= '0;
			bcnt_ff <= '0;
		end else begin
			obuf_ff <= nxt_obuf;
			bcnt_ff <= nxt_bcnt;
		end
	end

	// jitter measurement: reorder, accumulate, count unstable positions
	logic [ACC_W-1:0] acc_mem [KD];
	logic [POS_W-1:0] pos_ff;
	logic [POS_W-1:0] nxt_pos;
	logic [RND_W-1:0] rnd_ff;
	logic [RND_W-1:0] nxt_rnd;
	logic [UC_W-1:0] ucnt_ff;
	logic [UC_W-1:0] nxt_ucnt;
	logic [UC_W-1:0] jit_ff;
	logic [UC_W-1:0] nxt_jit;
	logic jit_valid_ff;
	logic nxt_jit_valid;
	logic [ACC_W-1:0] acc_new;
	logic [POS_W:0] pos_sum;
	logic unstable;

	always_comb begin
		pos_sum = {1'h0, pos_ff} + KM_STEP;
		nxt_pos = (pos_sum >= KD_EXT) ? POS_W'(pos_sum - KD_EXT) : pos_sum[POS_W-1:0];
		// the first round overwrites, so stale counts never survive a clear
		acc_new = (rnd_ff == '0) ? ACC_W'(sample) : acc_mem[pos_ff] + ACC_W'(sample);
		unstable = (acc_new != '0) && (acc_new < ACC_FULL);
		nxt_rnd = rnd_ff;
		nxt_ucnt = ucnt_ff;
		nxt_jit = jit_ff;
		nxt_jit_valid = jit_valid_ff;
		if (clr_ff) begin
			nxt_pos = '0;
			nxt_rnd = '0;
			nxt_ucnt = '0;
			nxt_jit = '0;
			nxt_jit_valid = 1'h0;
		end else begin
			if (rnd_ff == RND_LAST && unstable) begin
				nxt_ucnt = ucnt_ff + UC_W'(1);
			end
			if (end_period) begin
				nxt_pos = '0;
				if (rnd_ff == RND_LAST) begin
					nxt_rnd = '0;
					nxt_ucnt = '0;
					nxt_jit = unstable ? ucnt_ff + UC_W'(1) : ucnt_ff;
					nxt_jit_valid = 1'h1;
				end else begin
					nxt_rnd = rnd_ff + RND_W'(1);
				end
			end
		end
	end

	// memory holds no reset: it is cleared by the overwriting first round
	always_ff @(posedge clk_sys_i) begin
		if (!clr_ff) begin
			acc_mem[pos_ff] <= acc_new;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pos_ff <= '0;
			rnd_ff <= '0;
			ucnt_ff <= '0;
			jit_ff <= '0;
			jit_valid_ff <= 1'h0;
		end else begin
			pos_ff <= nxt_pos;
			rnd_ff <= nxt_rnd;
			ucnt_ff <= nxt_ucnt;
			jit_ff <= nxt_jit;
			jit_valid_ff <= nxt_jit_valid;
		end
	end

	// register port, lock error flags and alarm
	logic [LOCK_NUM-1:0] lerr_ff;
	logic [LOCK_NUM-1:0] nxt_lerr;
	logic [LOCK_NUM-1:0] lerr_clr;
	logic [DATA_W-1:0] rdat_ff;
	logic [DATA_W-1:0] nxt_rdat;
	logic alarm_ff;
	logic nxt_alarm;
	logic wr_ctrl;
	logic wr_status;

	assign wr_ctrl = reg_req_i.wr && reg_req_i.addr == ADDR_CTRL;
	assign wr_status = reg_req_i.wr && reg_req_i.addr == ADDR_STATUS;

	always_comb begin
		nxt_run = wr_ctrl ? reg_req_i.wdata[CTRL_RUN_BIT] : run_ff;
		nxt_clr = wr_ctrl && reg_req_i.wdata[CTRL_CLEAR_BIT];
		lerr_clr = wr_status ? reg_req_i.wdata[ST_LOCK_ERR_LSB +: LOCK_NUM] : '0;
		// a lock loss in the clearing cycle keeps its flag set
		nxt_lerr = (lerr_ff & ~lerr_clr) | ~lock_i;
		nxt_alarm = |nxt_lerr;
		nxt_rdat = '0;
		if (reg_req_i.rd) begin
			if (reg_req_i.addr == ADDR_CTRL) begin
				nxt_rdat[CTRL_RUN_BIT] = run_ff;
			end else if (reg_req_i.addr == ADDR_STATUS) begin
				nxt_rdat[ST_LOCK_ERR_LSB +: LOCK_NUM] = lerr_ff;
				nxt_rdat[ST_LOCKED_BIT] = locked_all;
				nxt_rdat[ST_BUF_FULL_BIT] = bcnt_ff == BUF_CNT_FULL;
			end else if (reg_req_i.addr == ADDR_JITTER) begin
				nxt_rdat[UC_W-1:0] = jit_ff;
				nxt_rdat[JIT_VALID_BIT] = jit_valid_ff;
			end else if (reg_req_i.addr[7:5] == BUF_PAGE && reg_req_i.addr[1:0] == 2'h0) begin
				nxt_rdat = obuf_ff[reg_req_i.addr[4:2]*DATA_W +: DATA_W];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_ff <= CTRL_RUN_RST;
			clr_ff <= 1'h0;
			lerr_ff <= '0;
			rdat_ff <= '0;
			alarm_ff <= 1'h0;
		end else begin
			run_ff <= nxt_run;
			clr_ff <= nxt_clr;
			lerr_ff <= nxt_lerr;
			rdat_ff <= nxt_rdat;
			alarm_ff <= nxt_alarm;
		end
	end

	assign rd_data_o = rdat_ff;
	assign raw_o = raw_ff;
	assign test_sample_o = tsamp_ff;
	assign alarm_o = alarm_ff;

	sequence s_period_end;
		!clr_ff && end_period;
	endsequence

	sequence s_locked_end;
		s_period_end ##0 run_ff && locked_all;
	endsequence

	a_period_wrap: assert property (s_period_end |=> cnt_ff == '0)
		else $error("period counter did not wrap after kd cycles");

	a_dec_cleared: assert property (s_period_end |=> dec_ff == 1'h0)
		else $error("decimator not cleared at period end");

	a_raw_bit_value: assert property (s_locked_end |=> raw_o.valid && raw_o.data == $past(period_bit))
		else $error("raw bit missing or not the period xor");

	a_raw_one_per: assert property (raw_o.valid |-> cnt_ff == '0 && !$past(raw_o.valid))
		else $error("raw bit issued outside one per period");

	a_lock_gate: assert property (!locked_all |=> !raw_o.valid)
		else $error("raw bit issued while a pll is unlocked");

	a_lock_err_set: assert property (!locked_all |=> ((lerr_ff | $past(lock_i)) == '1) && alarm_o)
		else $error("lock loss did not raise error flag and alarm");

	a_pos_step: assert property (!clr_ff && !end_period |=> pos_ff == $past(nxt_pos)
		&& ({1'h0, pos_ff} + KD_EXT - {1'h0, $past(pos_ff)}) % KD_EXT == KM_STEP)
		else $error("reorder position did not step by km mod kd");

	a_buf_shift: assert property (s_period_end ##0 locked_all |=> obuf_ff[0] == $past(period_bit))
		else $error("period bit not stored into output buffer");

	a_block_clear: assert property (clr_ff |=> cnt_ff == '0 && dec_ff == 1'h0 && rnd_ff == '0 && !jit_valid_ff)
		else $error("block clear left counters standing");

	a_jit_bound: assert property (jit_valid_ff |-> jit_ff <= UC_W'(KD))
		else $error("unstable count exceeds number of positions");

endmodule // trng_digitizer

// ===== shared/trng_digitizer_pkg.sv
/*
 * constants, register map and carrier types for the coherent-sampling digitizer.
 * assumes a single 250 MHz system clock and a plain one-cycle register port.
 */
package trng_digitizer_pkg;

	// sampling geometry defaults
	localparam int KM_DEF = 456;
	localparam int KD_DEF = 185;
	localparam int NPH_DEF = 2;
	localparam int ACC_N_DEF = 255;
	localparam int OBUF_BITS = 256;
	localparam int LOCK_NUM = 2;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_JITTER = 8'h08;
	localparam logic [7:0] ADDR_BUF_BASE = 8'h20;
	localparam logic [2:0] BUF_PAGE = 3'h1;

	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam int ST_LOCK_ERR_LSB = 0;
	localparam int ST_LOCKED_BIT = 2;
	localparam int ST_BUF_FULL_BIT = 3;
	localparam int JIT_VALID_BIT = 16;

	// reset values
	localparam logic CTRL_RUN_RST = 1'h1;

	typedef struct packed {
		logic valid;
		logic data;
	} raw_bit_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

endpackage

// ===== core/phase_sampler.sv
/*
 * samples k jittery clock phases as data on the reference clock and xors them.
 * assumes phase_i are free-running clocks from a pll, asynchronous to clk_sys_i.
 */
module phase_sampler import trng_digitizer_pkg::*; #(
	parameter int NPH = NPH_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic [NPH-1:0] phase_i,
	output logic sample_o
);

	logic [NPH-1:0] cap_ff;
	logic xor_ff;
	logic nxt_xor;

	// one capture flop per phase; nothing looks at a phase before this flop
	for (genvar p = 0; p < NPH; p++) begin : g_cap
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cap_ff[p] <= 1'h0;
			end else begin
				cap_ff[p] <= phase_i[p];
			end
		end
	end

	always_comb begin
		nxt_xor = clr_i ? 1'h0 : ^cap_ff;
	end

	// second stage gives metastable captures a full cycle to settle
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xor_ff <= 1'h0;
		end else begin
			xor_ff <= nxt_xor;
		end
	end

	assign sample_o = xor_ff;

	a_xor_of_phases: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!clr_i |=> xor_ff == ^$past(cap_ff)) else $error("sample is not the xor of captured phases");

endmodule // phase_sampler

// ===== testbench/raw_sink.sv
/*
 * model of the post-processing generator that is reseeded from the raw bit stream.
 * assumes raw_i is a registered one-cycle valid pulse on clk_sys_i.
 */
module raw_sink import trng_digitizer_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire raw_bit_s raw_i,
	output int pulses_o,
	output int gap_o,
	output logic bit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int since;

	// every bit is taken the cycle it arrives: the generator never pushes back
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulses_o <= 0;
			gap_o <= 0;
			since <= 0;
			bit_o <= 1'b0;
		end else if (raw_i.valid) begin
			pulses_o <= pulses_o + 1;
			gap_o <= since + 1;
			since <= 0;
			bit_o <= raw_i.data;
		end else begin
			since <= since + 1;
		end
	end
endmodule // raw_sink

// ===== testbench/pll_coherent_sampling_trng_digitizer_tb.sv
/*
 * self-checking bench for trng_digitizer with short factors km=5, kd=7, n=3.
 * assumes phases may be driven as plain data; a pattern repeating every kd cycles
 * gives a raw bit equal to its parity whatever the alignment to the period counter.
 */
module pll_coherent_sampling_trng_digitizer_tb import trng_digitizer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TKD = 7;
	localparam int TKM = 5;
	localparam int TACC = 3;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] phase_i = 2'h0;
	logic [LOCK_NUM-1:0] lock_i = 2'h3;
	reg_req_s req = '0;
	logic [DATA_W-1:0] rd_data_o;
	raw_bit_s raw_o;
	logic test_sample_o;
	logic alarm_o;
	int pulses, gap, n_mismatch, comparisons, idx, p0;
	logic last_bit, acc;
	logic odd = 1'b0;
	logic [1:0] pat [TKD];
	logic [TKD-1:0] flip = '0;
	logic [TKD-1:0] flips [4] = '{7'h00, 7'h01, 7'h12, 7'h54};

	trng_digitizer #(.KM(TKM), .KD(TKD), .NPH(2), .ACC_N(TACC)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.phase_i(phase_i), .lock_i(lock_i), .reg_req_i(req), .rd_data_o(rd_data_o), .raw_o(raw_o),
		.test_sample_o(test_sample_o), .alarm_o(alarm_o));
	raw_sink sink (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .raw_i(raw_o), .pulses_o(pulses), .gap_o(gap),
		.bit_o(last_bit));

	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	// flipped positions change only on odd passes, so they are unstable across rounds
	always @(posedge clk_sys_i) begin
		phase_i <= pat[idx] ^ {1'b0, flip[idx] & odd};
		idx <= (idx == TKD - 1) ? 0 : idx + 1;
		odd <= (idx == TKD - 1) ? ~odd : odd;
	end

	function automatic logic par();
		logic r = 1'b0;
		for (int i = 0; i < TKD; i++) r ^= pat[i][0] ^ pat[i][1];
		return r;
	endfunction

	function automatic logic differs(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		return got !== exp;
	endfunction

	task automatic fail(string what);
		n_mismatch++;
		$display("FAIL at %0t: %s", $time, what);
	endtask

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		@(posedge clk_sys_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys_i);
		req.wr <= 1'b0;
	endtask

	task automatic rd_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] m, logic [DATA_W-1:0] e);
		@(posedge clk_sys_i);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys_i);
		req.rd <= 1'b0;
		#1;
		if (differs(rd_data_o & m, e)) fail("register read");
	endtask

	task automatic new_pat(logic [TKD-1:0] f);
		int ph;
		int off;
		off = $urandom % (4 * TKD);
		// phase counted in steps of 1/(4*kd) of a phase period; the second phase lags the first by 90 degrees
		for (int i = 0; i < TKD; i++) begin
			ph = (i * 4 * TKM + off) % (4 * TKD);
			pat[i] = {ph >= TKD && ph < 3 * TKD, ph < 2 * TKD};
		end
		flip = f;
	endtask

	task automatic next_bit();
		p0 = pulses;
		for (int i = 0; i < 4 * TKD && pulses == p0; i++) @(posedge clk_sys_i);
		#1;
		if (differs(pulses, p0 + 1)) fail("no raw bit");
	endtask

	initial begin
		#40000;
		fail("watchdog");
		close_out();
	end

	initial begin
		void'($urandom(32'h3397));
		new_pat('0);
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
		rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
		for (int k = 0; k < 5; k++) begin
			new_pat('0);
			repeat (2 * TKD) @(posedge clk_sys_i);
			acc = 1'b0;
			for (int i = 0; i < TKD; i++) begin
				@(posedge clk_sys_i);
				#1;
				acc ^= test_sample_o;
			end
			if (differs(acc, par())) fail("test sample parity");
			next_bit();
			next_bit();
			if (differs(last_bit, par())) fail("raw bit value");
			if (differs(gap, TKD)) fail("raw bit spacing");
		end
		foreach (flips[k]) begin
			new_pat(flips[k]);
			repeat (4 * TACC * TKD) @(posedge clk_sys_i);
			rd_chk(ADDR_JITTER, 32'h000100FF, 32'h10000 | $countones(flips[k]));
		end
		new_pat('0);
		wr(ADDR_CTRL, 32'h3);
		rd_chk(ADDR_STATUS, 32'h8, 32'h0);
		repeat (260 * TKD) @(posedge clk_sys_i);
		rd_chk(ADDR_STATUS, 32'hC, 32'hC);
		rd_chk(ADDR_BUF_BASE, 32'hFFFFFFFF, {32{par()}});
		rd_chk(ADDR_BUF_BASE + 8'h1C, 32'hFFFFFFFF, {32{par()}});
		@(posedge clk_sys_i);
		lock_i <= 2'h1;
		repeat (2) @(posedge clk_sys_i);
		p0 = pulses;
		repeat (3 * TKD) @(posedge clk_sys_i);
		#1;
		if (differs(pulses, p0)) fail("output while unlocked");
		if (differs(alarm_o, 1'b1)) fail("alarm while unlocked");
		rd_chk(ADDR_STATUS, 32'h7, 32'h2);
		@(posedge clk_sys_i);
		lock_i <= 2'h3;
		wr(ADDR_STATUS, 32'h2);
		rd_chk(ADDR_STATUS, 32'h7, 32'h4);
		repeat (2) @(posedge clk_sys_i);
		#1;
		if (differs(alarm_o, 1'b0)) fail("alarm after clear");
		wr(ADDR_CTRL, 32'h0);
		// a bit launched in the write cycle may still reach the sink at the next edge
		@(posedge clk_sys_i);
		#1;
		p0 = pulses;
		repeat (3 * TKD) @(posedge clk_sys_i);
		#1;
		if (differs(pulses, p0)) fail("output while stopped");
		wr(ADDR_CTRL, 32'h3);
		rd_chk(ADDR_STATUS, 32'h8, 32'h0);
		next_bit();
		close_out();
	end
endmodule // pll_coherent_sampling_trng_digitizer_tb
